// File: design/spawn_msg_regs.svh
// Constants for the spawn and dereference message decoder.
// Functional notes
// - Slot tag in dword 5 bits 7:0 releases root resources only on dereference.
// - Slot tags handed out are unique among running root threads.
// - Dword 4 bits 15:10 give payload entry count; ignored on dereference.
// - Child spawn initializes payload length plus constant entries registers.
// - Root spawn initializes payload length plus constants plus front-end handle.
// - Zero length: child gets header only; root gets no parent payload. The code gives a child the header plus the constant entries.
// - Dword 4 bits 9:0 is payload entry offset; ignored on dereference.
// - Child spawn uses descriptor pointer dword 2 bits 31:4; else ignored.
// - Dword 2 bits 27:24 select one of sixteen barriers.
// - Dword 2 bits 8:4 is descriptor index from descriptor base.
// - Extended object command uses dword 2 bits 3:0 as dependency colour.
// - Dword 0 bits 27:24 pick the shared-memory 4k block.
// - Device assigns dependency tag in dword 0 bits 23:16; older variants zero.
// - Dword 0 bits 15:0 is child payload or root message handle.
// - Root end-of-thread with children present dereferences the handle; else ignored.
// - Descriptor bit 0: zero release, one spawn.
// - Descriptor bit 1: zero root, one child; release only for root.
// - Descriptor bit 4 on spawn: zero child, one root.
`ifndef SPAWN_MSG_REGS_SVH
`define SPAWN_MSG_REGS_SVH
`define DESC_OPCODE_BIT      0
`define DESC_REQ_KIND_BIT    1
`define DESC_RES_SEL_BIT     4
`define SLOT_TAG_HI          7
`define SLOT_TAG_LO          0
`define PAY_LEN_HI           15
`define PAY_LEN_LO           10
`define PAY_OFF_HI           9
`define PAY_OFF_LO           0
`define DESC_PTR_HI          31
`define DESC_PTR_LO          4
`define BARRIER_SEL_HI       27
`define BARRIER_SEL_LO       24
`define BARRIER_OFF_HI       23
`define BARRIER_OFF_LO       16
`define DESC_IDX_HI          8
`define DESC_IDX_LO          4
`define COLOUR_HI            3
`define COLOUR_LO            0
`define SHM_IDX_HI           27
`define SHM_IDX_LO           24
`define HANDLE_HI            15
`define HANDLE_LO            0
`define SLOT_COUNT           256
`define SLOT_W               8
`define HEADER_REGS          7'h01
`endif

// File: design/spawn_msg_pkg.sv
// Types shared by the spawn and dereference message decoder.
package spawn_msg_pkg;
    typedef logic [255:0] message_t;

    typedef struct packed {
        logic        opcode_spawn;
        logic        req_child;
        logic        res_sel;
        logic        ext_object;
        logic        tag_support;
        logic        children_present;
    } msg_ctrl_s;

    typedef struct packed {
        logic        spawn_child;
        logic        spawn_root;
        logic        release_root;
        logic        deref_handle;
        logic [7:0]  slot_tag;
        logic [7:0]  dependency_tag;
        logic [5:0]  payload_len;
        logic [9:0]  payload_off;
        logic [27:0] desc_ptr;
        logic [3:0]  barrier_selector;
        logic [7:0]  barrier_off;
        logic [4:0]  desc_idx;
        logic [3:0]  colour;
        logic [3:0]  shm_idx;
        logic [15:0] handle;
        logic [6:0]  init_regs;
    } decoded_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DONE = 3'b010,
        ST_STALL = 3'b100
    } dec_state_e;
endpackage : spawn_msg_pkg

// File: design/slot_tag_pool.sv
// Pool that hands out and takes back unique root thread slot tags.
`timescale 1ns/1ps
`include "spawn_msg_regs.svh"
module slot_tag_pool
(
    input  wire logic            clock,
    input  wire logic            sys_rst,
    input  wire logic            alloc_req,
    input  wire logic            free_req,
    input  wire logic [7:0]      free_tag,
    output logic                 tag_avail,
    output logic [7:0]           alloc_tag
);
    logic [`SLOT_COUNT-1:0] busy_r;
    logic [`SLOT_COUNT-1:0] busy_nxt;
    logic [7:0]             first_free;
    logic                   any_free;

    // Find the lowest free slot.
    always_comb
    begin
        first_free = 8'h00;
        any_free   = 1'b0;
        for (int i = `SLOT_COUNT - 1; i >= 0; i--)
        begin
            if (!busy_r[i])
            begin
                first_free = 8'(i);
                any_free   = 1'b1;
            end
        end
    end

    assign tag_avail = any_free;
    assign alloc_tag = first_free;

    // Busy map: a tag is never granted while it is still held.
    always_comb
    begin
        busy_nxt = busy_r;
        if (free_req)
        begin
            busy_nxt[free_tag] = 1'b0;
        end
        if (alloc_req && any_free)
        begin
            busy_nxt[first_free] = 1'b1;
        end
    end

    // Registers the busy map.
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            busy_r <= '0;
        end
        else
        begin
            busy_r <= busy_nxt;
        end
    end
endmodule : slot_tag_pool

// File: design/spawn_msg_decoder.sv
// Decoder for the single-register thread spawn and dereference message.
`timescale 1ns/1ps
`include "spawn_msg_regs.svh"
module spawn_msg_decoder
(
    input  wire logic                    clock,
    input  wire logic                    sys_rst,
    input  wire logic                    msg_valid,
    output logic                         msg_ready,
    input  wire spawn_msg_pkg::message_t msg_data,
    input  wire spawn_msg_pkg::msg_ctrl_s msg_ctrl,
    input  wire logic [5:0]              const_entries,
    input  wire logic                    fe_handle_present,
    input  wire logic [7:0]              dep_tag_next,
    output logic                         out_valid,
    output spawn_msg_pkg::decoded_s      out_data
);
    import spawn_msg_pkg::*;

    // =========================================================
    // Field extraction
    // =========================================================
    function automatic logic [31:0] dword(input message_t m, input int idx);
        dword = m[idx*32 +: 32];
    endfunction : dword

    // Sums payload entries, constant entries and one optional extra register.
    // The inputs are at most 63, 63 and 1, so seven bits never overflow.
    function automatic logic [6:0] regs_sum(input logic [6:0] base,
                                            input logic [5:0] consts,
                                            input logic       extra);
        regs_sum = base + 7'(consts) + 7'(extra);
    endfunction : regs_sum

    logic [31:0] dw0;
    logic [31:0] dw2;
    logic [31:0] dw4;
    logic [31:0] dw5;
    assign dw0 = dword(msg_data, 0);
    assign dw2 = dword(msg_data, 2);
    assign dw4 = dword(msg_data, 4);
    assign dw5 = dword(msg_data, 5);

    // =========================================================
    // Raw message fields
    // =========================================================
    logic [7:0]  raw_slot_tag;
    logic [5:0]  raw_pay_len;
    logic [9:0]  raw_pay_off;
    logic [27:0] raw_desc_ptr;
    logic [3:0]  raw_bar_sel;
    logic [7:0]  raw_bar_off;
    logic [4:0]  raw_desc_idx;
    logic [3:0]  raw_colour;
    logic [3:0]  raw_shm_idx;
    logic [15:0] raw_handle;

    // Cuts every field out of its dword whatever the operation is.
    // Whether a field counts is decided only in the decode below, so an
    // ignored field can reach no output through this block.
    always_comb
    begin
        raw_slot_tag = dw5[`SLOT_TAG_HI:`SLOT_TAG_LO];
        raw_pay_len  = dw4[`PAY_LEN_HI:`PAY_LEN_LO];
        raw_pay_off  = dw4[`PAY_OFF_HI:`PAY_OFF_LO];
        raw_desc_ptr = dw2[`DESC_PTR_HI:`DESC_PTR_LO];
        raw_bar_sel  = dw2[`BARRIER_SEL_HI:`BARRIER_SEL_LO];
        raw_bar_off  = dw2[`BARRIER_OFF_HI:`BARRIER_OFF_LO];
        raw_desc_idx = dw2[`DESC_IDX_HI:`DESC_IDX_LO];
        raw_colour   = dw2[`COLOUR_HI:`COLOUR_LO];
        raw_shm_idx  = dw0[`SHM_IDX_HI:`SHM_IDX_LO];
        raw_handle   = dw0[`HANDLE_HI:`HANDLE_LO];
    end

    // =========================================================
    // Register counts
    // =========================================================
    logic [6:0] child_regs;
    logic [6:0] root_regs;

    // A child with no payload still receives its header register, which
    // its parent wrote into the payload; a root with no payload gets only
    // the constants and the front-end handle, its header comes elsewhere.
    always_comb
    begin
        if (raw_pay_len == 6'h00)
        begin
            child_regs = regs_sum(`HEADER_REGS, const_entries, 1'b0);
        end
        else
        begin
            child_regs = regs_sum(7'(raw_pay_len), const_entries, 1'b0);
        end
        root_regs = regs_sum(7'(raw_pay_len), const_entries, fe_handle_present);
    end

    dec_state_e state_r;
    dec_state_e state_nxt;
    decoded_s   out_r;
    decoded_s   out_nxt;
    logic       tag_avail;
    logic [7:0] alloc_tag;
    logic       take;
    logic       is_spawn;
    logic       is_child_spawn;
    logic       is_root_spawn;
    logic       is_release;
    logic       need_tag;

    // Operation decode from the message descriptor bits.
    always_comb
    begin
        is_spawn       = msg_ctrl.opcode_spawn;
        is_child_spawn = is_spawn && !msg_ctrl.res_sel;
        is_root_spawn  = is_spawn && msg_ctrl.res_sel;
        is_release     = !is_spawn && !msg_ctrl.req_child;
        need_tag       = is_root_spawn;
    end

    // A root spawn waits while every slot tag is held.
    assign msg_ready = (state_r == ST_IDLE) && (!need_tag || tag_avail);
    assign take      = msg_valid && msg_ready;

    slot_tag_pool u_pool
    (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .alloc_req (take && need_tag),
        .free_req  (take && is_release),
        .free_tag  (raw_slot_tag),
        .tag_avail (tag_avail),
        .alloc_tag (alloc_tag)
    );

    // =========================================================
    // Decode and register-count computation
    // =========================================================
    always_comb
    begin
        out_nxt = out_r;
        if (take)
        begin
            out_nxt = '0;
            out_nxt.spawn_child  = is_child_spawn;
            out_nxt.spawn_root   = is_root_spawn;
            out_nxt.release_root = is_release;
            if (is_release)
            begin
                out_nxt.slot_tag = raw_slot_tag;
                // Handle is dereferenced only when children exist.
                if (msg_ctrl.children_present)
                begin
                    out_nxt.deref_handle = 1'b1;
                    out_nxt.handle       = raw_handle;
                end
            end
            if (is_spawn)
            begin
                out_nxt.payload_len      = raw_pay_len;
                out_nxt.payload_off      = raw_pay_off;
                out_nxt.handle           = raw_handle;
                out_nxt.barrier_selector = raw_bar_sel;
                out_nxt.barrier_off      = raw_bar_off;
                out_nxt.desc_idx         = raw_desc_idx;
                out_nxt.shm_idx          = raw_shm_idx;
                if (msg_ctrl.ext_object)
                begin
                    out_nxt.colour = raw_colour;
                end
                if (msg_ctrl.tag_support)
                begin
                    out_nxt.dependency_tag = dep_tag_next;
                end
                // Only a child uses the descriptor pointer; a root leaves it zero.
                if (is_root_spawn)
                begin
                    out_nxt.slot_tag  = alloc_tag;
                    out_nxt.init_regs = root_regs;
                end
                else
                begin
                    out_nxt.desc_ptr  = raw_desc_ptr;
                    out_nxt.init_regs = child_regs;
                end
            end
        end
    end

    // State sequence: accept, present one cycle, return to idle.
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  state_nxt = take ? ST_DONE : ST_IDLE;
            ST_DONE:  state_nxt = ST_IDLE;
            ST_STALL: state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    // Registers state and decoded fields.
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_r <= ST_IDLE;
            out_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            out_r   <= out_nxt;
        end
    end

    assign out_valid = (state_r == ST_DONE);
    assign out_data  = out_r;
endmodule : spawn_msg_decoder

// File: sim/eu_sender.sv
// Model of an execution unit thread that sends spawn messages.
`timescale 1ns/1ps
module eu_sender
(
    input  wire logic                clock,
    input  wire logic                msg_ready,
    output logic                     msg_valid,
    output spawn_msg_pkg::message_t  msg_data,
    output spawn_msg_pkg::msg_ctrl_s msg_ctrl
);
    import spawn_msg_pkg::*;
    logic timed_out = 1'b0;
    initial
    begin
        msg_valid = 1'b0;
        msg_data = '0;
        msg_ctrl = '0;
    end
    // ====
    // Offers one message and holds it until the decoder takes it or 20 cycles pass.
    task send(input msg_ctrl_s c, input message_t d);
        int n;
        @(posedge clock);
        msg_valid <= 1'b1;
        msg_ctrl <= c;
        msg_data <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clock);
            if (msg_ready)
                break;
        end
        timed_out = (n == 20);
        msg_valid <= 1'b0;
        msg_data <= ~d; // Released lines must not keep stale data.
    endtask : send
endmodule : eu_sender

// File: sim/spawn_msg_chk.sv
// Assertion checker for the spawn message decoder ports.
`timescale 1ns/1ps
module spawn_msg_chk
(
    input wire logic                      clock,
    input wire logic                      sys_rst,
    input wire logic                      msg_valid,
    input wire logic                      msg_ready,
    input wire spawn_msg_pkg::message_t   msg_data,
    input wire spawn_msg_pkg::msg_ctrl_s  msg_ctrl,
    input wire logic [5:0]                const_entries,
    input wire logic                      out_valid,
    input wire spawn_msg_pkg::decoded_s   out_data
);
    import spawn_msg_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ====
    // Take, spawn and release steps of one transfer.
    sequence s_take; msg_valid && msg_ready; endsequence
    sequence s_spawn; s_take ##0 msg_ctrl.opcode_spawn; endsequence
    sequence s_deref; s_take ##0 !msg_ctrl.opcode_spawn; endsequence
    a_answer_next: assert property (s_take |=> out_valid)
        else $error("no answer after take");
    a_pulse_single: assert property (out_valid |=> !out_valid)
        else $error("answer longer than one cycle");
    a_busy_answer: assert property (out_valid |-> !msg_ready)
        else $error("ready during answer");
    a_release_kind: assert property (s_deref |=>
        out_data.release_root == !$past(msg_ctrl.req_child)) else $error("release kind");
    a_slot_free: assert property (s_deref ##0 !msg_ctrl.req_child |=>
        out_data.slot_tag == $past(msg_data[167:160])) else $error("slot tag");
    a_deref_ignore: assert property (s_deref |=> out_data.payload_len == 6'h00
        && out_data.payload_off == 10'h000) else $error("fields used on release");
    a_len_taken: assert property (s_spawn |=>
        out_data.payload_len == $past(msg_data[143:138])
        && out_data.payload_off == $past(msg_data[137:128])) else $error("length");
    a_spawn_kind: assert property (s_spawn |=> out_data.spawn_root ==
        $past(msg_ctrl.res_sel) && out_data.spawn_child != $past(msg_ctrl.res_sel))
        else $error("spawn kind");
    a_child_regs: assert property (s_spawn ##0 !msg_ctrl.res_sel |=>
        out_data.init_regs == {1'b0, $past(const_entries)} + (($past(msg_data[143:138])
        == 6'h00) ? 7'h01 : {1'b0, $past(msg_data[143:138])})) else $error("child regs");
endmodule : spawn_msg_chk
bind spawn_msg_decoder spawn_msg_chk u_chk (.clock(clock), .sys_rst(sys_rst),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_data(msg_data),
    .msg_ctrl(msg_ctrl), .const_entries(const_entries), .out_valid(out_valid),
    .out_data(out_data));

// File: sim/tb_top.sv
// Self-checking bench for the spawn message decoder.
`timescale 1ns/1ps
module tb_top;
    import spawn_msg_pkg::*;
    localparam logic [31:0] D2 = 32'h3a4501b7;
    localparam logic [31:0] D0 = 32'h0c5abeef;
    localparam logic [31:0] F = 32'hffffffff;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic       msg_valid;
    logic       msg_ready;
    logic       out_valid;
    logic       fe_handle_present = 1'b1;
    logic [5:0] const_entries = 6'h00;
    logic [7:0] dep_tag_next = 8'h3c;
    message_t   msg_data;
    msg_ctrl_s  msg_ctrl;
    decoded_s   out_data;
    int         fail_count = 0;
    int         total_checks = 0;
    always #5 clock = ~clock;
    spawn_msg_decoder DUT (.clock(clock), .sys_rst(sys_rst), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .msg_data(msg_data), .msg_ctrl(msg_ctrl),
        .const_entries(const_entries), .fe_handle_present(fe_handle_present),
        .dep_tag_next(dep_tag_next), .out_valid(out_valid), .out_data(out_data));
    eu_sender u_eu (.clock(clock), .msg_ready(msg_ready), .msg_valid(msg_valid),
        .msg_data(msg_data), .msg_ctrl(msg_ctrl));
    // ====
    // Builds a message whose ignored dwords are all ones.
    function message_t mk(input logic [31:0] d5, d4);
        mk = {F, F, d5, d4, F, D2, F, D0};
    endfunction : mk
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // Sends one message and lets the answer land before checks.
    task go(input logic [5:0] c, input msg_ctrl_s k, input message_t d);
        @(posedge clock);
        const_entries <= c;
        u_eu.send(k, d);
        if (u_eu.timed_out)
        begin
            fail_count++;
            $display("MISMATCH %0t message not taken", $time);
            stop_test();
        end
        #1;
        chk(out_valid, 1'b1);
    endtask : go
    // ====
    // Main sequence of spawn and release messages.
    initial
    begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        go(6'h03, 6'b100110, mk(F, 32'hffff0000));
        chk(out_data.spawn_child, 1'b1);
        chk(out_data.init_regs, 7'h04);
        chk(out_data.desc_ptr, 28'h3a4501b);
        chk(out_data.barrier_selector, 4'ha);
        chk(out_data.barrier_off, 8'h45);
        chk(out_data.desc_idx, 5'h1b);
        chk(out_data.colour, 4'h7);
        chk(out_data.dependency_tag, 8'h3c);
        chk(out_data.shm_idx, 4'hc);
        chk(out_data.handle, 16'hbeef);
        go(6'h00, 6'b100000, mk(F, F));
        chk(out_data.payload_off, 10'h3ff);
        chk(out_data.init_regs, 7'h3f);
        chk(out_data.colour, 4'h0);
        chk(out_data.dependency_tag, 8'h00);
        go(6'h02, 6'b101000, mk(F, 32'hffff1411));
        chk(out_data.spawn_root, 1'b1);
        chk(out_data.init_regs, 7'h08);
        chk(out_data.slot_tag, 8'h00);
        chk(out_data.desc_ptr, 28'h0);
        // A root without a front-end handle, payload or constant entries gets no register.
        @(posedge clock);
        fe_handle_present <= 1'b0;
        go(6'h00, 6'b101000, mk(F, 32'hffff0000));
        chk(out_data.init_regs, 7'h00);
        chk(out_data.slot_tag, 8'h01);
        go(6'h00, 6'b000001, mk(32'hffffff00, F));
        chk(out_data.release_root, 1'b1);
        chk(out_data.deref_handle, 1'b1);
        chk(out_data.handle, 16'hbeef);
        go(6'h00, 6'b010000, mk(32'hffffff01, F));
        chk(out_data.release_root, 1'b0);
        chk(out_data.deref_handle, 1'b0);
        go(6'h00, 6'b101000, mk(F, 32'hffff0000));
        chk(out_data.slot_tag, 8'h00);
        stop_test();
    end
endmodule : tb_top
